// ==== core/ripple_counter_pkg.sv ====
package ripple_counter_pkg;
    localparam int COUNT_W = 4;
    localparam int UPPER_W = 3;
    localparam int PIN_W = 8;
    localparam int PIN_CLK1 = 0;
    localparam int PIN_CLK2 = 1;
    localparam int PIN_LOAD_N = 2;
    localparam int PIN_CLEAR_N = 3;
    localparam int PIN_DATA_LSB = 4;
    localparam logic [PIN_W-1:0] PIN_RESET = 8'h0F;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
    localparam logic [UPPER_W-1:0] UPPER_ZERO = 3'h0;
    localparam logic [UPPER_W-1:0] UPPER_ONE = 3'h1;
    localparam logic [UPPER_W-1:0] DIV5_LAST = 3'h4;
endpackage

// ==== core/pin_filter.sv ====
`timescale 1ns/1ps
module pin_filter #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] agree;

    // First stage feeds only the second, against metastability
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            stage1_r <= RESET_VAL;
            stage2_r <= RESET_VAL;
            stage3_r <= RESET_VAL;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    assign agree = ~(stage2_r ^ stage3_r);

    // A change counts only once two late stages agree
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            level_r <= RESET_VAL;
        end else begin
            level_r <= (agree & stage3_r) | (~agree & level_r);
        end
    end

    assign level_out = level_r;
endmodule // pin_filter

// ==== core/ripple_counter_latch.sv ====
`timescale 1ns/1ps
module ripple_counter_latch
    import ripple_counter_pkg::*;
#(
    parameter bit DECADE = 1'b1
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic clk1_in,
    input wire logic clk2_in,
    input wire logic load_n_in,
    input wire logic clear_n_in,
    input wire logic [ripple_counter_pkg::COUNT_W-1:0] data_in,
    output logic count_bit0_out,
    output logic count_bit1_out,
    output logic count_bit2_out,
    output logic count_bit3_out
);
    import ripple_counter_pkg::*;

    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] level;
    logic clk1_prev_r;
    logic clk2_prev_r;
    logic fall1;
    logic fall2;
    logic counting;
    logic [COUNT_W-1:0] data_lvl;
    logic low_r;
    logic [UPPER_W-1:0] upper_r;
    logic [UPPER_W-1:0] upper_nxt;

    assign pins = {data_in, clear_n_in, load_n_in, clk2_in, clk1_in};

    pin_filter #(
        .WIDTH(PIN_W),
        .RESET_VAL(PIN_RESET)
    ) u_filter (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .pin_in(pins),
        .level_out(level)
    );

    assign data_lvl = level[PIN_DATA_LSB +: COUNT_W];

    always_ff @(posedge clock_in) begin
        // Reset to the idle pin level, so release gives no false edge
        if (srst_in) begin
            clk1_prev_r <= PIN_RESET[PIN_CLK1];
            clk2_prev_r <= PIN_RESET[PIN_CLK2];
        end else begin
            clk1_prev_r <= level[PIN_CLK1];
            clk2_prev_r <= level[PIN_CLK2];
        end
    end

    // Falling edges only; rising edges do nothing
    assign fall1 = clk1_prev_r & ~level[PIN_CLK1];
    assign fall2 = clk2_prev_r & ~level[PIN_CLK2];
    // Edge is lost if load or clear is low when it lands
    assign counting = level[PIN_CLEAR_N] & level[PIN_LOAD_N];

    // Decade wraps after four; loaded states above four also return to zero
    always_comb begin
        if (DECADE && (upper_r >= DIV5_LAST)) begin
            upper_nxt = UPPER_ZERO;
        end else begin
            upper_nxt = upper_r + UPPER_ONE;
        end
    end

    // Divide-by-two stage
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            low_r <= COUNT_RESET[0];
        end else if (!level[PIN_CLEAR_N]) begin
            low_r <= COUNT_RESET[0];
        end else if (!level[PIN_LOAD_N]) begin
            low_r <= data_lvl[0];
        end else if (counting && fall1) begin
            low_r <= ~low_r;
        end else begin
            low_r <= low_r;
        end
    end

    // Upper stage on its own clock, so cascade order is free
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            upper_r <= COUNT_RESET[COUNT_W-1:1];
        end else if (!level[PIN_CLEAR_N]) begin
            upper_r <= COUNT_RESET[COUNT_W-1:1];
        end else if (!level[PIN_LOAD_N]) begin
            upper_r <= data_lvl[COUNT_W-1:1];
        end else if (counting && fall2) begin
            upper_r <= upper_nxt;
        end else begin
            upper_r <= upper_r;
        end
    end

    // Bit zero leaves straight from its flop so it can clock stage two
    assign count_bit0_out = low_r;
    assign count_bit1_out = upper_r[0];
    assign count_bit2_out = upper_r[1];
    assign count_bit3_out = upper_r[2];

    // Checks watch filtered levels, so pin latency stays out of them
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    AST_CLEAR_ZERO: assert property (
        !level[PIN_CLEAR_N] |=> {upper_r, low_r} == COUNT_RESET)
        else $error("clear did not zero the count");

    AST_CLEAR_WINS: assert property (
        !level[PIN_CLEAR_N] && !level[PIN_LOAD_N] && (data_lvl != COUNT_RESET)
        |=> {upper_r, low_r} == COUNT_RESET)
        else $error("load overrode clear");

    AST_LOAD_PRESET: assert property (
        level[PIN_CLEAR_N] && !level[PIN_LOAD_N] && (fall1 || fall2)
        |=> {upper_r, low_r} == $past(data_lvl))
        else $error("preset lost to a clock edge");

    AST_LATCH_FOLLOW: assert property (
        (level[PIN_CLEAR_N] && !level[PIN_LOAD_N]) [*2]
        |=> {upper_r, low_r} == $past(data_lvl))
        else $error("latch did not follow data");

    AST_HOLD: assert property (
        counting && !fall1 && !fall2 |=> {upper_r, low_r} == $past({upper_r, low_r}))
        else $error("count changed without a clock edge");

    AST_LOW_TOGGLE: assert property (
        counting && fall1 |=> low_r != $past(low_r))
        else $error("divide-by-two stage missed an edge");

    AST_UPPER_STEP: assert property (
        counting && fall2 && (upper_r < DIV5_LAST || !DECADE)
        |=> upper_r == $past(upper_r) + UPPER_ONE)
        else $error("upper stage did not step by one");

    AST_DIV5_WRAP: assert property (
        DECADE && counting && fall2 && (upper_r == DIV5_LAST) |=> upper_r == UPPER_ZERO)
        else $error("decade stage did not wrap after four");

    AST_STAGES_APART: assert property (
        counting && fall1 && !fall2 |=> upper_r == $past(upper_r))
        else $error("stage two moved on a stage one edge");

    AST_LOW_APART: assert property (
        counting && fall2 && !fall1
        |=> low_r == $past(low_r))
        else $error("stage one moved on a stage two edge");

    AST_RISE_IGNORED: assert property (
        counting && !clk1_prev_r && level[PIN_CLK1]
        |=> low_r == $past(low_r))
        else $error("divide-by-two stage moved on a rising edge");

    AST_UPPER_RISE_IGNORED: assert property (
        counting && !clk2_prev_r && level[PIN_CLK2]
        |=> upper_r == $past(upper_r))
        else $error("upper stage moved on a rising edge");

    AST_DIV8_WRAP: assert property (
        !DECADE && counting && fall2 && (&upper_r)
        |=> upper_r == UPPER_ZERO)
        else $error("binary stage did not wrap after seven");

    // Loaded states above four are legal in the decade build and must not lock up
    AST_HIGH_STATE_WRAP: assert property (
        DECADE && counting && fall2 && (upper_r > DIV5_LAST)
        |=> upper_r == UPPER_ZERO)
        else $error("decade stage stuck above four");

    // Preset is level sensitive: every cycle of low load with clear high copies the data
    AST_PRESET_ANY: assert property (
        level[PIN_CLEAR_N] && !level[PIN_LOAD_N]
        |=> {upper_r, low_r} == $past(data_lvl))
        else $error("preset did not take the data");

    AST_PRESET_LOW_CLOCKS: assert property (
        level[PIN_CLEAR_N] && !level[PIN_LOAD_N] && !level[PIN_CLK1] && !level[PIN_CLK2]
        |=> {upper_r, low_r} == $past(data_lvl))
        else $error("preset blocked by low clocks");

    AST_DATA_FOLLOW: assert property (
        level[PIN_CLEAR_N] && !level[PIN_LOAD_N] && $changed(data_lvl)
        |=> {upper_r, low_r} == $past(data_lvl))
        else $error("latch missed a data change");

    AST_CLEAR_BEATS_EDGE: assert property (
        !level[PIN_CLEAR_N] && (fall1 || fall2)
        |=> {upper_r, low_r} == COUNT_RESET)
        else $error("clock edge beat clear");

    // Main scenarios the bench should reach
    COV_LATCH: cover property (level[PIN_CLEAR_N] && !level[PIN_LOAD_N] ##1 level[PIN_LOAD_N]);
    COV_DIV5_WRAP: cover property (DECADE && counting && fall2 && upper_r == DIV5_LAST);
    COV_CLEAR_AND_LOAD: cover property (!level[PIN_CLEAR_N] && !level[PIN_LOAD_N]);
    COV_BOTH_EDGES: cover property (counting && fall1 && fall2);
    COV_HIGH_WRAP: cover property (DECADE && counting && fall2 && upper_r > DIV5_LAST);
endmodule // ripple_counter_latch

// ==== tb/pin_driver.sv ====
`timescale 1ns/1ps
module pin_driver (
    input wire logic clock_in,
    output logic clk1_out,
    output logic clk2_out,
    output logic load_n_out,
    output logic clear_n_out,
    output logic [ripple_counter_pkg::COUNT_W-1:0] data_out
);
    import ripple_counter_pkg::*;
    initial begin
        clk1_out = 1'b1;
        clk2_out = 1'b1;
        load_n_out = 1'b1;
        clear_n_out = 1'b1;
        data_out = 4'h0;
    end
    // Each level stands six periods, above the four the pin filter takes to pass it
    task automatic drive(input logic c1, input logic c2, input logic ld_n, input logic cl_n,
                         input logic [COUNT_W-1:0] d);
        @(posedge clock_in);
        #2;
        clk1_out = c1;
        clk2_out = c2;
        load_n_out = ld_n;
        clear_n_out = cl_n;
        data_out = d;
        repeat (6) @(posedge clock_in);
    endtask
endmodule // pin_driver

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    import ripple_counter_pkg::*;
    logic clock_in, srst_in, clk1, clk2s, load_n, clear_n, casc;
    logic [COUNT_W-1:0] data, q_dec, q_bin;
    int mismatches = 0;
    int cmp_count = 0;
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    pin_driver i_drv (.clock_in(clock_in), .clk1_out(clk1), .clk2_out(clk2s), .load_n_out(load_n),
        .clear_n_out(clear_n), .data_out(data));
    // Cascade ties each second clock to its own bit zero
    ripple_counter_latch #(.DECADE(1'b1)) i_dut (.clock_in(clock_in), .srst_in(srst_in), .clk1_in(clk1),
        .clk2_in(casc ? q_dec[0] : clk2s), .load_n_in(load_n), .clear_n_in(clear_n), .data_in(data),
        .count_bit0_out(q_dec[0]), .count_bit1_out(q_dec[1]), .count_bit2_out(q_dec[2]),
        .count_bit3_out(q_dec[3]));
    ripple_counter_latch #(.DECADE(1'b0)) i_bin (.clock_in(clock_in), .srst_in(srst_in), .clk1_in(clk1),
        .clk2_in(casc ? q_bin[0] : clk2s), .load_n_in(load_n), .clear_n_in(clear_n), .data_in(data),
        .count_bit0_out(q_bin[0]), .count_bit1_out(q_bin[1]), .count_bit2_out(q_bin[2]),
        .count_bit3_out(q_bin[3]));
    task automatic check(input logic [COUNT_W-1:0] got, input logic [COUNT_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic test_latch;
        i_drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h3);
        check(q_bin, 4'h3);
        i_drv.drive(1'b0, 1'b0, 1'b0, 1'b1, 4'h9);
        check(q_dec, 4'h9);
        check(q_bin, 4'h9);
        i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        check(q_dec, 4'h9);
    endtask
    task automatic test_clear;
        i_drv.drive(1'b1, 1'b1, 1'b0, 1'b0, 4'h6);
        check(q_bin, 4'h0);
        i_drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h7);
        i_drv.drive(1'b0, 1'b0, 1'b1, 1'b0, 4'h5);
        check(q_bin, 4'h0);
        i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h5);
    endtask
    // Bit zero pulses clock the upper stage, giving BCD and full binary
    task automatic test_count;
        i_drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
        // Cascade goes in while load is low, so the clock-two drop it makes is refused
        #2;
        casc = 1'b1;
        i_drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
        i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        check(q_dec, COUNT_RESET);
        check(q_bin, COUNT_RESET);
        for (int n = 1; n <= 16; n++) begin
            i_drv.drive(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
            check({UPPER_ZERO, q_dec[0]}, COUNT_W'(n % 2));
            i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
            check(q_dec, COUNT_W'(n % 10));
            check(q_bin, COUNT_W'(n % 16));
        end
        #2;
        casc = 1'b0;
    endtask
    task automatic test_upper;
        i_drv.drive(1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
        i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        for (int n = 1; n <= 9; n++) begin
            i_drv.drive(1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
            check(q_dec, {UPPER_W'(n % 5), 1'b0});
            check(q_bin, {UPPER_W'(n % 8), 1'b0});
            i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        end
        i_drv.drive(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
        check(q_dec, 4'h1);
        check(q_bin, 4'h5);
        i_drv.drive(1'b1, 1'b1, 1'b0, 1'b1, 4'hE);
        i_drv.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'hE);
        check(q_dec, 4'hE);
        i_drv.drive(1'b1, 1'b0, 1'b1, 1'b1, 4'hE);
        check(q_dec, 4'h0);
        check(q_bin, 4'h0);
    endtask
    initial begin
        srst_in = 1'b1;
        casc = 1'b0;
        repeat (20) @(posedge clock_in);
        #2;
        srst_in = 1'b0;
        repeat (6) @(posedge clock_in);
        check(q_dec, COUNT_RESET);
        check(q_bin, COUNT_RESET);
        test_latch();
        test_clear();
        test_count();
        test_upper();
        complete_run();
    end
    // Whole run takes about 490 cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        mismatches++;
        complete_run();
    end
endmodule // tb
